/* File: design/srak_consts.svh */
// constants for the service request and acknowledge logic
`ifndef SRAK_CONSTS_SVH
`define SRAK_CONSTS_SVH
`define SRAK_PIR_REQ_BIT 7
`define SRAK_PIR_PORT_BIT 6
`define SRAK_PIR_PIPE_BIT 5
`define SRAK_PIPE_FIFO_CTRL_REG_INT_ENABLE_BIT_BIT 4
`define SRAK_SVC_REQUEST_STATUS_REG_DMA_BIT 7
`define SRAK_SVC_REQUEST_STATUS_REG_SRQ_BIT 3
`define SRAK_SRC_MASK 8'h07
`define SRAK_SRC_PORT 3'h4
`define SRAK_SRC_PIPE 3'h5
`define SRAK_SRC_BOTH 3'h6
`define SRAK_VEC_RESET 8'h00
`endif

/* File: design/srak_pkg.sv */
// types for the service request and acknowledge logic
package srak_pkg;
   typedef enum logic [1:0] {
      SRAK_IDLE = 2'b00,
      SRAK_REQ = 2'b01,
      SRAK_SERVICE = 2'b10
   } srak_state_type;
endpackage

/* File: design/srak_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module srak_sync (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_reset_val,
   input wire logic i_async,
   output logic o_sync
);
   logic stage1;
   // reset value comes from a constant tie at the instance
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         stage1 <= i_reset_val;
         o_sync <= i_reset_val;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule

/* File: design/srak_service_req.sv */
// service request, vectored acknowledge and dma status logic
//
// Notes on behaviour
// - read with acknowledge low drives local vector onto data bus
// - acknowledge low drops the service request output
// - interrupt enable cleared then set ends service
// - with dma enabled, threshold crossing shows in status bit 7
// - with dma enabled, fifo data only through dma buffer, 16-bit bus
// - status bit mask 0x08 shows an active service request
// - vector low bits: 4 port, 5 pipeline, 6 both
// - interrupt register bits show port, pipeline or both as source
`timescale 1ns/100ps
`include "srak_consts.svh"
module srak_service_req (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_svc_ack_n,
   input wire logic i_host_rd,
   input wire logic i_port_event,
   input wire logic i_pipe_event,
   input wire logic [7:0] i_vector_base,
   input wire logic i_pending_clear,
   input wire logic i_int_enable_bit,
   input wire logic i_dma_enable,
   input wire logic i_fifo_threshold,
   input wire logic i_bus_16bit,
   output logic o_svc_req_n,
   output logic [7:0] o_data,
   output logic o_data_oe,
   output logic [7:0] o_par_int_reg,
   output logic [7:0] o_local_vector,
   output logic [7:0] o_svc_request_status_reg,
   output logic o_dma_buffer_ok,
   output logic o_fifo_poll_needed
);
   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   logic ack_n_s;
   srak_sync u_ack_sync (
      .i_clk(i_clk),
      .i_sys_rst(i_sys_rst),
      .i_reset_val(1'b1),
      .i_async(i_svc_ack_n),
      .o_sync(ack_n_s)
   );

   srak_pkg::srak_state_type state;
   logic port_src;
   logic pipe_src;
   logic en_d;
   logic toggle_done;
   logic ack_read;
   logic [2:0] next_src;
   logic late_port;
   logic late_pipe;

   // a falling then rising edge of the enable bit ends service
   assign toggle_done = i_int_enable_bit & ~en_d;
   assign ack_read = ~ack_n_s & i_host_rd;

   function automatic logic [2:0] src_code(input logic port, input logic pipe);
      if (port && pipe) begin
         src_code = `SRAK_SRC_BOTH;
      end else if (pipe) begin
         src_code = `SRAK_SRC_PIPE;
      end else begin
         src_code = `SRAK_SRC_PORT;
      end
   endfunction

   assign next_src = src_code(port_src | i_port_event, pipe_src | i_pipe_event);

   // ---------------------------------------------------------------
   // enable edge tracking
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         en_d <= 1'b1;
      end else begin
         en_d <= i_int_enable_bit;
      end
   end

   // ---------------------------------------------------------------
   // request state machine
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= srak_pkg::SRAK_IDLE;
      end else begin
         unique case (state)
            srak_pkg::SRAK_IDLE: begin
               // sources recorded while enable was low or during service raise it here
               if ((port_src | pipe_src | i_port_event | i_pipe_event) && i_int_enable_bit) begin
                  state <= srak_pkg::SRAK_REQ;
               end
            end
            srak_pkg::SRAK_REQ: begin
               // held until acknowledged or pending bit cleared
               if (!ack_n_s || i_pending_clear) begin
                  state <= srak_pkg::SRAK_SERVICE;
               end
            end
            srak_pkg::SRAK_SERVICE: begin
               // no new request until the enable toggle
               if (toggle_done) begin
                  state <= srak_pkg::SRAK_IDLE;
               end
            end
            default: begin
               state <= srak_pkg::SRAK_IDLE;
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // source capture, events during service are kept for the next one
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         port_src <= 1'b0;
         pipe_src <= 1'b0;
      end else if (state == srak_pkg::SRAK_SERVICE && toggle_done) begin
         // sources of the finished service drop, late ones take their place
         port_src <= late_port | i_port_event;
         pipe_src <= late_pipe | i_pipe_event;
      end else if (state != srak_pkg::SRAK_SERVICE) begin
         port_src <= port_src | i_port_event;
         pipe_src <= pipe_src | i_pipe_event;
      end
   end

   // events during service wait here, so the source bits keep naming the one being served
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         late_port <= 1'b0;
         late_pipe <= 1'b0;
      end else if (state != srak_pkg::SRAK_SERVICE || toggle_done) begin
         late_port <= 1'b0;
         late_pipe <= 1'b0;
      end else begin
         late_port <= late_port | i_port_event;
         late_pipe <= late_pipe | i_pipe_event;
      end
   end

   // ---------------------------------------------------------------
   // visible registers and pins
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_svc_req_n <= 1'b1;
         o_par_int_reg <= 8'h00;
         o_local_vector <= `SRAK_VEC_RESET;
         o_svc_request_status_reg <= 8'h00;
      end else begin
         // deasserted on acknowledge or clear
         o_svc_req_n <= !(state == srak_pkg::SRAK_REQ && ack_n_s && !i_pending_clear);
         o_par_int_reg[`SRAK_PIR_REQ_BIT] <= (state == srak_pkg::SRAK_REQ) && !i_pending_clear;
         o_par_int_reg[`SRAK_PIR_PORT_BIT] <= port_src | i_port_event;
         o_par_int_reg[`SRAK_PIR_PIPE_BIT] <= pipe_src | i_pipe_event;
         o_par_int_reg[4:0] <= 5'h00;
         o_local_vector <= {i_vector_base[7:3], next_src & 3'(`SRAK_SRC_MASK)};
         o_svc_request_status_reg[`SRAK_SVC_REQUEST_STATUS_REG_SRQ_BIT] <= (state == srak_pkg::SRAK_REQ);
         o_svc_request_status_reg[`SRAK_SVC_REQUEST_STATUS_REG_DMA_BIT] <= i_dma_enable & i_fifo_threshold;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_dma_buffer_ok <= 1'b0;
         o_fifo_poll_needed <= 1'b1;
      end else begin
         o_dma_buffer_ok <= i_dma_enable & i_bus_16bit;
         o_fifo_poll_needed <= ~i_dma_enable;
      end
   end

   // vector driven during an acknowledge read cycle
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_data <= 8'h00;
         o_data_oe <= 1'b0;
      end else begin
         o_data_oe <= ack_read;
         o_data <= ack_read ? {i_vector_base[7:3], next_src} : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_ack_drops_req;
      @(posedge i_clk) disable iff (i_sys_rst) !ack_n_s |=> o_svc_req_n;
   endproperty
   a_ack_drops_req: assert property (p_ack_drops_req) else $error("request not dropped on ack");

   property p_ack_read_vec;
      @(posedge i_clk) disable iff (i_sys_rst) ack_read |=> o_data_oe && o_data[2:0] == $past(next_src);
   endproperty
   a_ack_read_vec: assert property (p_ack_read_vec) else $error("vector not driven");

   property p_clear_drops;
      @(posedge i_clk) disable iff (i_sys_rst) i_pending_clear |=> o_svc_req_n && !o_par_int_reg[7];
   endproperty
   a_clear_drops: assert property (p_clear_drops) else $error("clear ignored");

   property p_service_holds;
      @(posedge i_clk) disable iff (i_sys_rst)
         state == srak_pkg::SRAK_SERVICE && !toggle_done |=> state == srak_pkg::SRAK_SERVICE;
   endproperty
   a_service_holds: assert property (p_service_holds) else $error("service ended early");

   property p_toggle_ends;
      @(posedge i_clk) disable iff (i_sys_rst)
         state == srak_pkg::SRAK_SERVICE && toggle_done |=> state == srak_pkg::SRAK_IDLE;
   endproperty
   a_toggle_ends: assert property (p_toggle_ends) else $error("toggle missed");

   property p_dma_flag;
      @(posedge i_clk) disable iff (i_sys_rst)
         ##1 o_svc_request_status_reg[7] == ($past(i_dma_enable) && $past(i_fifo_threshold));
   endproperty
   a_dma_flag: assert property (p_dma_flag) else $error("dma flag wrong");

   property p_status_req;
      @(posedge i_clk) disable iff (i_sys_rst) ##1 o_svc_request_status_reg[3] == ($past(state) == srak_pkg::SRAK_REQ);
   endproperty
   a_status_req: assert property (p_status_req) else $error("status bit wrong");

   property p_src_both;
      @(posedge i_clk) disable iff (i_sys_rst) port_src && pipe_src |=> o_local_vector[2:0] == 3'h6;
   endproperty
   a_src_both: assert property (p_src_both) else $error("source code wrong");

   property p_pir_src;
      @(posedge i_clk) disable iff (i_sys_rst) pipe_src |=> o_par_int_reg[5];
   endproperty
   a_pir_src: assert property (p_pir_src) else $error("pipeline source lost");

   property p_dma_buf;
      @(posedge i_clk) disable iff (i_sys_rst) !i_bus_16bit |=> !o_dma_buffer_ok;
   endproperty
   a_dma_buf: assert property (p_dma_buf) else $error("dma buffer on 8-bit bus");
endmodule

/* File: verification/srak_host_model.sv */
// host cpu model driving acknowledge, software clear and interrupt enable
`timescale 1ns/100ps
module srak_host_model (
   input wire logic i_clk,
   input wire logic i_data_oe,
   input wire logic [7:0] i_data,
   output logic o_ack_n,
   output logic o_rd,
   output logic o_clear,
   output logic o_int_en
);
   initial begin
      o_ack_n = 1'b1;
      o_rd = 1'b0;
      o_clear = 1'b0;
      o_int_en = 1'b1;
   end
   // ack and read held until the data bus answers, bounded so a dead device cannot hang us
   task automatic ack_read(output logic [7:0] vec);
      int n;
      n = 0;
      @(posedge i_clk);
      o_ack_n <= 1'b0;
      o_rd <= 1'b1;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_data_oe !== 1'b1 && n < 20);
      vec = i_data;
      o_ack_n <= 1'b1;
      o_rd <= 1'b0;
   endtask
   // no acknowledge cycle: pending bit removed by software
   task automatic sw_clear();
      @(posedge i_clk);
      o_clear <= 1'b1;
      @(posedge i_clk);
      o_clear <= 1'b0;
   endtask
   // enable low then high tells the device that service is over
   task automatic end_service();
      @(posedge i_clk);
      o_int_en <= 1'b0;
      @(posedge i_clk);
      o_int_en <= 1'b1;
   endtask
endmodule

/* File: verification/service_request_ack_logic_tb_top.sv */
// self-checking bench for the service request and acknowledge logic
`timescale 1ns/100ps
module service_request_ack_logic_tb_top;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic port_ev = 1'b0;
   logic pipe_ev = 1'b0;
   logic dma_en = 1'b0;
   logic thr = 1'b0;
   logic b16 = 1'b0;
   logic [7:0] vbase = 8'hA8;
   logic ack_n, rd, clr, int_en, req_n, oe, poll, dok;
   logic [7:0] data, par_int_reg, vec, svc_request_status_reg, v;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;
   always #2.5 i_clk = ~i_clk;
   srak_service_req srak_service_req_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_svc_ack_n(ack_n),
      .i_host_rd(rd), .i_port_event(port_ev), .i_pipe_event(pipe_ev), .i_vector_base(vbase),
      .i_pending_clear(clr), .i_int_enable_bit(int_en), .i_dma_enable(dma_en), .i_fifo_threshold(thr),
      .i_bus_16bit(b16), .o_svc_req_n(req_n), .o_data(data), .o_data_oe(oe), .o_par_int_reg(par_int_reg),
      .o_local_vector(vec), .o_svc_request_status_reg(svc_request_status_reg), .o_dma_buffer_ok(dok),
      .o_fifo_poll_needed(poll));
   srak_host_model srak_host_model_i (.i_clk(i_clk), .i_data_oe(oe), .i_data(data), .o_ack_n(ack_n),
      .o_rd(rd), .o_clear(clr), .o_int_en(int_en));
   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   task automatic do_reset(int n);
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (n) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      repeat (2) @(posedge i_clk);
   endtask
   // pulse the chosen sources, then wait a bounded time for the request pin
   task automatic raise(logic p, logic q);
      int n;
      n = 0;
      @(posedge i_clk);
      port_ev <= p;
      pipe_ev <= q;
      @(posedge i_clk);
      port_ev <= 1'b0;
      pipe_ev <= 1'b0;
      while (req_n !== 1'b0 && n < 10) begin
         @(posedge i_clk);
         n++;
      end
      @(negedge i_clk);
      check("svc_req_n", {7'h00, req_n}, 8'h00);
      check("svc_request_status_reg", svc_request_status_reg, 8'h08);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   // vectored acknowledge; port and then both sources on a fresh reset
   task automatic run_ack(logic q, logic [2:0] code, logic [7:0] pexp);
      do_reset(2);
      raise(1'b1, q);
      check("par_int_reg", par_int_reg, pexp);
      check("local_vector", vec, {vbase[7:3], code});
      srak_host_model_i.ack_read(v);
      check("ack data", v, {vbase[7:3], code});
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      check("svc_req_n", {7'h00, req_n}, 8'h01);
      srak_host_model_i.end_service();
   endtask
   // software clear; a new event in service must not raise a request before the toggle
   task automatic run_clear();
      do_reset(2);
      raise(1'b0, 1'b1);
      check("local_vector", vec, {vbase[7:3], 3'h5});
      check("par_int_reg", par_int_reg, 8'hA0);
      srak_host_model_i.sw_clear();
      // a port event in service is only recorded, so no request comes yet
      @(posedge i_clk);
      port_ev <= 1'b1;
      @(posedge i_clk);
      port_ev <= 1'b0;
      repeat (4) @(posedge i_clk);
      @(negedge i_clk);
      check("svc_req_n", {7'h00, req_n}, 8'h01);
      check("svc_request_status_reg", svc_request_status_reg, 8'h00);
      srak_host_model_i.end_service();
      repeat (6) @(posedge i_clk);
      @(negedge i_clk);
      check("svc_req_n", {7'h00, req_n}, 8'h00);
      check("local_vector", vec, {vbase[7:3], 3'h4});
   endtask
   task automatic run_dma();
      do_reset(2);
      dma_en <= 1'b1;
      thr <= 1'b1;
      b16 <= 1'b1;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      check("svc_request_status_reg", svc_request_status_reg, 8'h80);
      check("dma_buffer_ok", {7'h00, dok}, 8'h01);
      check("fifo_poll", {7'h00, poll}, 8'h00);
      @(posedge i_clk);
      b16 <= 1'b0;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      check("dma_buffer_ok", {7'h00, dok}, 8'h00);
      @(posedge i_clk);
      dma_en <= 1'b0;
      repeat (3) @(posedge i_clk);
      @(negedge i_clk);
      check("fifo_poll", {7'h00, poll}, 8'h01);
      check("svc_request_status_reg", svc_request_status_reg, 8'h00);
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         print_verdict();
      end
   end
   initial begin
      repeat (10) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      run_ack(1'b0, 3'h4, 8'hC0);
      run_ack(1'b1, 3'h6, 8'hE0);
      run_clear();
      run_dma();
      print_verdict();
   end
endmodule
